// ==== hw/mpr_regs.vh ====
// Constants for the meter pulse input and relay output block
`ifndef MPR_REGS_VH
`define MPR_REGS_VH

`define MPR_CLK_NS          10
`define MPR_TICK_NS         1000000
`define MPR_MS_CLKS         (`MPR_TICK_NS / `MPR_CLK_NS)
`define MPR_HALF_CYC_NS     10000000
`define MPR_HALF_CLKS       (`MPR_HALF_CYC_NS / `MPR_CLK_NS)

`define MPR_DB_MIN          10'h001
`define MPR_DB_MAX          10'h064
`define MPR_DB_DEF          7'h0A
`define MPR_PW_MIN          10'h00A
`define MPR_PW_MAX          10'h3E8
`define MPR_PW_DEF          10'h064

`define MPR_MODE_UNLATCHED  2'h0
`define MPR_MODE_LATCHED    2'h1
`define MPR_MODE_PULSE      2'h2
`define MPR_MODE_KYZ        2'h3

`define MPR_SRC_NONE        3'h0
`define MPR_SRC_NUM         7

`endif

// ==== hw/mpr_debounce.v ====
// Debounce and edge qualification for one digital input
`timescale 1ns/1ps
`include "mpr_regs.vh"
module mpr_debounce
(
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_ce,
    input  wire       i_tick,
    // Configuration
    input  wire [6:0] i_db_ms,
    input  wire       i_kyz,
    input  wire       i_inv,
    // Contact
    input  wire       i_raw,
    // Results
    output reg        o_state,
    output reg        o_event
);
    reg        raw_q;
    reg  [6:0] cnt_q;
    wire       accept;

    // Stable strictly longer than the count, so never shorter than set
    assign accept = (raw_q != o_state) && (cnt_q > i_db_ms);

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            raw_q   <= 1'b0;
            cnt_q   <= 7'h00;
            o_state <= 1'b0;
            o_event <= 1'b0;
        end
        else if (i_ce)
        begin
            raw_q   <= i_raw;
            o_event <= 1'b0;
            if (i_raw != raw_q)
                cnt_q <= 7'h00;
            else if (i_tick && cnt_q != 7'h7F)
                cnt_q <= cnt_q + 7'h01;
            if (accept)
            begin
                o_state <= raw_q;
                if (i_kyz)
                    o_event <= 1'b1;
                else
                    o_event <= raw_q ^ i_inv;
            end
        end
    end
endmodule // mpr_debounce

// ==== hw/mpr_top.v ====
// Pulse inputs and one relay output channel of a metering instrument
`timescale 1ns/1ps
`include "mpr_regs.vh"
module mpr_top
#(
    parameter N_IN      = 2,
    parameter MS_CLKS   = `MPR_MS_CLKS,
    parameter HALF_CLKS = `MPR_HALF_CLKS,
    parameter PEND_W    = 8,
    parameter WEIGHT_W  = 20
)
(
    // Clock and reset
    input  wire                i_clk,
    input  wire                i_rst,
    input  wire                i_ce,
    // Digital inputs
    input  wire [N_IN-1:0]     i_din,
    input  wire [N_IN-1:0]     i_din_kyz,
    input  wire [N_IN-1:0]     i_din_inv,
    input  wire [6:0]          i_db_ms,
    output reg  [N_IN-1:0]     o_din_state,
    output reg  [N_IN-1:0]     o_din_event,
    // Relay configuration
    input  wire [1:0]          i_relay_mode,
    input  wire                i_relay_inv,
    input  wire                i_retain,
    input  wire                i_saved_state,
    input  wire [9:0]          i_pulse_ms,
    input  wire [2:0]          i_src_sel,
    input  wire [WEIGHT_W-1:0] i_weight,
    // Relay control sources
    input  wire                i_sp_operate,
    input  wire                i_sp_release,
    input  wire                i_cmd_valid,
    input  wire                i_cmd_on,
    input  wire [6:0]          i_energy_pulse,
    // Relay results
    output reg                 o_relay_coil,
    output reg                 o_relay_state,
    output reg                 o_relay_busy
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ON   = 2'h1;
    localparam ST_OFF  = 2'h2;

    function [9:0] clampv;
        input [9:0] v;
        input [9:0] lo;
        input [9:0] hi;
        begin
            if (v < lo)
                clampv = lo;
            else if (v > hi)
                clampv = hi;
            else
                clampv = v;
        end
    endfunction

    reg  [31:0]         tick_cnt_q;
    reg                 tick_q;
    wire [9:0]          db_clamp;
    wire [6:0]          db_eff;
    wire [9:0]          pw_eff;
    wire [N_IN-1:0]     din_state;
    wire [N_IN-1:0]     din_event;

    reg  [1:0]          st_q;
    reg  [1:0]          st_d;
    reg                 act_q;
    reg                 act_d;
    reg                 init_q;
    reg                 sp_q;
    reg                 restart;
    reg  [31:0]         lms_q;
    reg  [31:0]         hc_q;
    reg  [10:0]         ms_el_q;
    wire                tdone;
    reg  [WEIGHT_W-1:0] wcnt_q;
    reg  [PEND_W-1:0]   pend_q;
    reg                 take;
    wire                pulsed;
    wire                sp_rise;
    wire                src_hit;
    wire                w_ev;
    wire                trig;
    wire [WEIGHT_W-1:0] weight_eff;
    wire [2:0]          src_idx;

    // Millisecond tick shared by every input debounce; relay timing keeps its own count
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end
        else if (i_ce)
        begin
            if (tick_cnt_q == MS_CLKS - 1)
            begin
                tick_cnt_q <= 32'h0;
                tick_q     <= 1'b1;
            end
            else
            begin
                tick_cnt_q <= tick_cnt_q + 32'h1;
                tick_q     <= 1'b0;
            end
        end
    end

    // One clamped debounce value feeds every input
    assign db_clamp = clampv({3'h0, i_db_ms}, `MPR_DB_MIN, `MPR_DB_MAX);
    assign db_eff   = db_clamp[6:0];

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi = gi + 1)
        begin : g_din
            mpr_debounce u_db
            (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_ce    (i_ce),
                .i_tick  (tick_q),
                .i_db_ms (db_eff),
                .i_kyz   (i_din_kyz[gi]),
                .i_inv   (i_din_inv[gi]),
                .i_raw   (i_din[gi]),
                .o_state (din_state[gi]),
                .o_event (din_event[gi])
            );
        end
    endgenerate

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_din_state <= {N_IN{1'b0}};
            o_din_event <= {N_IN{1'b0}};
        end
        else if (i_ce)
        begin
            o_din_state <= din_state;
            o_din_event <= din_event;
        end
    end

    // Energy source link and pulse weight
    assign pw_eff  = clampv(i_pulse_ms, `MPR_PW_MIN, `MPR_PW_MAX);
    assign pulsed  = (i_relay_mode == `MPR_MODE_PULSE) ||
                     (i_relay_mode == `MPR_MODE_KYZ);
    assign src_idx = i_src_sel - 3'h1;
    assign src_hit = pulsed && (i_src_sel != `MPR_SRC_NONE) &&
                     i_energy_pulse[src_idx];
    assign weight_eff = (i_weight == {WEIGHT_W{1'b0}}) ?
                        {{(WEIGHT_W-1){1'b0}}, 1'b1} : i_weight;
    // Each energy strobe is one least unit; weight counts them
    assign w_ev = src_hit && (wcnt_q + {{(WEIGHT_W-1){1'b0}}, 1'b1}
                              >= weight_eff);

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            wcnt_q <= {WEIGHT_W{1'b0}};
        else if (i_ce)
        begin
            if (!pulsed)
                wcnt_q <= {WEIGHT_W{1'b0}};
            else if (w_ev)
                wcnt_q <= {WEIGHT_W{1'b0}};
            else if (src_hit)
                wcnt_q <= wcnt_q + {{(WEIGHT_W-1){1'b0}}, 1'b1};
        end
    end

    // Triggers merged in one cycle count once; the trade for a plain queue
    assign sp_rise = i_sp_operate && !sp_q;
    assign trig    = pulsed && (w_ev || sp_rise ||
                                (i_cmd_valid && i_cmd_on) ||
                                (i_cmd_valid && i_relay_mode ==
                                 `MPR_MODE_KYZ));

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            pend_q <= {PEND_W{1'b0}};
        else if (i_ce)
        begin
            if (!pulsed)
                pend_q <= {PEND_W{1'b0}};
            else if (trig && !take && pend_q != {PEND_W{1'b1}})
                pend_q <= pend_q + {{(PEND_W-1){1'b0}}, 1'b1};
            else if (take && !trig)
                pend_q <= pend_q - {{(PEND_W-1){1'b0}}, 1'b1};
        end
    end

    // Interval timer: ends on a half-cycle edge once the width has passed
    // Counts the millisecond ending on this edge, so exact multiples fit
    assign tdone = (hc_q == HALF_CLKS - 1) &&
                   ({1'b0, ms_el_q} + {11'h000, lms_q == MS_CLKS - 1} >=
                    {2'h0, pw_eff});

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lms_q   <= 32'h0;
            hc_q    <= 32'h0;
            ms_el_q <= 11'h000;
        end
        else if (i_ce)
        begin
            if (restart)
            begin
                lms_q   <= 32'h0;
                hc_q    <= 32'h0;
                ms_el_q <= 11'h000;
            end
            else
            begin
                if (lms_q == MS_CLKS - 1)
                begin
                    lms_q <= 32'h0;
                    if (ms_el_q != 11'h7FF)
                        ms_el_q <= ms_el_q + 11'h001;
                end
                else
                    lms_q <= lms_q + 32'h1;
                if (hc_q == HALF_CLKS - 1)
                    hc_q <= 32'h0;
                else
                    hc_q <= hc_q + 32'h1;
            end
        end
    end

    // Relay state machine
    always @*
    begin
        st_d    = st_q;
        act_d   = act_q;
        restart = 1'b0;
        take    = 1'b0;
        case (i_relay_mode)
            `MPR_MODE_UNLATCHED:
            begin
                st_d  = ST_IDLE;
                act_d = i_sp_operate;
            end
            `MPR_MODE_LATCHED:
            begin
                st_d = ST_IDLE;
                if (i_cmd_valid)
                    act_d = i_cmd_on;
                else if (sp_rise)
                    act_d = 1'b1;
                else if (i_sp_release)
                    act_d = 1'b0;
            end
            default:
            begin
                case (st_q)
                    ST_IDLE:
                    begin
                        if (pend_q != {PEND_W{1'b0}})
                        begin
                            take    = 1'b1;
                            restart = 1'b1;
                            if (i_relay_mode == `MPR_MODE_KYZ)
                            begin
                                act_d = !act_q;
                                st_d  = ST_OFF;
                            end
                            else
                            begin
                                act_d = 1'b1;
                                st_d  = ST_ON;
                            end
                        end
                        else if (i_relay_mode == `MPR_MODE_PULSE)
                            act_d = 1'b0;
                    end
                    ST_ON:
                    begin
                        if (tdone)
                        begin
                            act_d   = 1'b0;
                            restart = 1'b1;
                            st_d    = ST_OFF;
                        end
                    end
                    ST_OFF:
                    begin
                        if (tdone)
                            st_d = ST_IDLE;
                    end
                    default:
                    begin
                        st_d  = ST_IDLE;
                        act_d = 1'b0;
                    end
                endcase
            end
        endcase
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q          <= ST_IDLE;
            act_q         <= 1'b0;
            init_q        <= 1'b0;
            sp_q          <= 1'b0;
            o_relay_coil  <= 1'b0;
            o_relay_state <= 1'b0;
            o_relay_busy  <= 1'b0;
        end
        else if (i_ce)
        begin
            init_q <= 1'b1;
            sp_q   <= i_sp_operate;
            if (!init_q)
            begin
                // Saved level sampled only after reset release
                st_q <= ST_IDLE;
                if (i_relay_mode == `MPR_MODE_LATCHED && i_retain)
                begin
                    act_q        <= i_saved_state;
                    o_relay_coil <= i_saved_state ^ i_relay_inv;
                    o_relay_state <= i_saved_state;
                end
                else
                begin
                    act_q         <= 1'b0;
                    o_relay_coil  <= i_relay_inv;
                    o_relay_state <= 1'b0;
                end
                o_relay_busy <= 1'b0;
            end
            else
            begin
                st_q          <= st_d;
                act_q         <= act_d;
                o_relay_coil  <= act_d ^ i_relay_inv;
                o_relay_state <= act_d;
                o_relay_busy  <= (st_d != ST_IDLE);
            end
        end
    end
endmodule // mpr_top

// ==== sim/mpr_contact.sv ====
// Dry contact model: settles to a level or chatters like a bouncing contact
`timescale 1ns/1ps
module mpr_contact
(
    // Clock
    input  wire logic i_clk,
    // Control from the bench
    input  wire logic i_level,
    input  wire logic i_chatter,
    // Contact seen by the block
    output logic      o_din
);
    initial o_din = 1'b0;

    // Chatter flips every cycle, so it never looks stable to the debouncer
    always @(posedge i_clk)
    begin
        o_din <= i_chatter ? ~o_din : i_level;
    end
endmodule // mpr_contact

// ==== sim/mpr_monitor.sv ====
// Assertion checker for the pulse input and relay block
`timescale 1ns/1ps
`include "mpr_regs.vh"
module mpr_monitor
#(
    parameter N_IN      = 2,
    parameter MS_CLKS   = 10,
    parameter HALF_CLKS = 20
)
(
    // Clock and reset
    input  wire            i_clk,
    input  wire            i_rst,
    // Digital inputs
    input  wire [N_IN-1:0] i_din,
    input  wire [N_IN-1:0] i_din_kyz,
    input  wire [N_IN-1:0] i_din_inv,
    input  wire [6:0]      i_db_ms,
    input  wire [N_IN-1:0] o_din_state,
    input  wire [N_IN-1:0] o_din_event,
    // Relay
    input  wire [1:0]      i_relay_mode,
    input  wire            i_relay_inv,
    input  wire            i_retain,
    input  wire            i_saved_state,
    input  wire [9:0]      i_pulse_ms,
    input  wire            i_sp_operate,
    input  wire            o_relay_coil,
    input  wire            o_relay_state
);
    int         stab_q;
    int         run_q;
    logic       last_q;
    logic [9:0] w;
    int         wmin;
    int         wmax;

    // Width is clamped, then rounded up to whole half cycles
    always @*
    begin
        w = (i_pulse_ms < 10'h00A) ? 10'h00A :
            (i_pulse_ms > 10'h3E8) ? 10'h3E8 : i_pulse_ms;
        wmin = int'(w) * MS_CLKS;
        wmax = ((wmin + HALF_CLKS - 1) / HALF_CLKS) * HALF_CLKS;
    end

    // Run lengths saturate so a long idle never wraps to a short one
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stab_q <= 0;
            run_q  <= 60000;
            last_q <= 1'b0;
        end
        else
        begin
            stab_q <= $changed(i_din[0]) ? 0 :
                      (stab_q < 60000) ? stab_q + 1 : stab_q;
            run_q  <= (o_relay_state != last_q) ? 1 :
                      (run_q < 60000) ? run_q + 1 : run_q;
            last_q <= o_relay_state;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_sp_on;
        i_relay_mode == `MPR_MODE_UNLATCHED && $rose(i_sp_operate);
    endsequence
    sequence s_sp_off;
        i_relay_mode == `MPR_MODE_UNLATCHED && $fell(i_sp_operate);
    endsequence

    a_event_one_cycle:
        assert property (o_din_event[0] |=> !o_din_event[0])
        else $error("input event longer than one cycle");
    a_event_has_cause:
        assert property (o_din_event[0] |-> $changed(o_din_state[0]))
        else $error("input event without a state change");
    a_edge_polarity:
        assert property ($changed(o_din_state[0]) && !i_din_kyz[0] |->
            o_din_event[0] == (o_din_state[0] ^ i_din_inv[0]))
        else $error("input event on the wrong edge");
    a_kyz_both_edges:
        assert property ($changed(o_din_state[0]) && i_din_kyz[0] |->
            o_din_event[0])
        else $error("both-edge input missed an edge");
    a_debounce_min:
        assert property ($changed(o_din_state[0]) |->
            stab_q >= int'(i_db_ms) * MS_CLKS)
        else $error("input accepted before debounce time");
    a_coil_polarity:
        assert property (!$past(i_rst) |->
            o_relay_coil == (o_relay_state ^ $past(i_relay_inv)))
        else $error("coil does not match state and polarity");
    a_unlatch_on:
        assert property (s_sp_on |-> ##[1:3] o_relay_state)
        else $error("unlatched relay did not follow setpoint");
    a_unlatch_off:
        assert property (s_sp_off |-> ##[1:3] !o_relay_state)
        else $error("unlatched relay did not release");
    a_restore_state:
        assert property ($fell(i_rst) |=> o_relay_state ==
            (i_relay_mode == `MPR_MODE_LATCHED && i_retain && i_saved_state))
        else $error("relay state after reset is wrong");
    a_pulse_width:
        assert property ($fell(o_relay_state) &&
            i_relay_mode == `MPR_MODE_PULSE |-> run_q >= wmin && run_q <= wmax)
        else $error("relay pulse width out of range");
    a_pulse_pause:
        assert property ($rose(o_relay_state) &&
            i_relay_mode == `MPR_MODE_PULSE |-> run_q >= wmin)
        else $error("pause between relay pulses too short");
endmodule // mpr_monitor

bind mpr_top mpr_monitor #(.N_IN(N_IN), .MS_CLKS(MS_CLKS),
    .HALF_CLKS(HALF_CLKS)) u_mon (.i_clk(i_clk), .i_rst(i_rst),
    .i_din(i_din), .i_din_kyz(i_din_kyz), .i_din_inv(i_din_inv),
    .i_db_ms(i_db_ms), .o_din_state(o_din_state),
    .o_din_event(o_din_event), .i_relay_mode(i_relay_mode),
    .i_relay_inv(i_relay_inv), .i_retain(i_retain),
    .i_saved_state(i_saved_state), .i_pulse_ms(i_pulse_ms),
    .i_sp_operate(i_sp_operate), .o_relay_coil(o_relay_coil),
    .o_relay_state(o_relay_state));

// ==== sim/tb_top.sv ====
// Self-checking bench for the pulse input and relay block
`timescale 1ns/1ps
`include "mpr_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
    logic        i_clk          = 1'b0;
    logic        i_rst          = 1'b1;
    logic        i_ce           = 1'b1;
    logic [1:0]  lvl            = 2'h0;
    logic [1:0]  chat           = 2'h0;
    wire  [1:0]  i_din;
    logic [1:0]  i_din_kyz      = 2'h0;
    logic [1:0]  i_din_inv      = 2'h0;
    logic [6:0]  i_db_ms        = 7'h02;
    logic [1:0]  i_relay_mode   = 2'h0;
    logic        i_relay_inv    = 1'b0;
    logic        i_retain       = 1'b0;
    logic        i_saved_state  = 1'b0;
    logic [9:0]  i_pulse_ms     = 10'h00A;
    logic [2:0]  i_src_sel      = 3'h0;
    logic [19:0] i_weight       = 20'h00002;
    logic        i_sp_operate   = 1'b0;
    logic        i_sp_release   = 1'b0;
    logic        i_cmd_valid    = 1'b0;
    logic        i_cmd_on       = 1'b0;
    logic [6:0]  i_energy_pulse = 7'h00;
    logic [1:0]  o_din_state;
    logic [1:0]  o_din_event;
    logic        o_relay_coil;
    logic        o_relay_state;
    logic        o_relay_busy;
    int          fail_count     = 0;
    int          compares       = 0;
    int          ev0            = 0;
    int          rises          = 0;

    always #5 i_clk = ~i_clk;

    always @(posedge i_clk)
    begin
        if (o_din_event[0] === 1'b1) ev0++;
        if ($rose(o_relay_state)) rises++;
    end

    mpr_contact u_c0 (.i_clk(i_clk), .i_level(lvl[0]), .i_chatter(chat[0]),
        .o_din(i_din[0]));
    mpr_contact u_c1 (.i_clk(i_clk), .i_level(lvl[1]), .i_chatter(chat[1]),
        .o_din(i_din[1]));

    // Short tick and half cycle keep the run brief; HALF forces rounding
    mpr_top #(.N_IN(2), .MS_CLKS(10), .HALF_CLKS(30)) uut (.i_clk(i_clk),
        .i_rst(i_rst), .i_ce(i_ce), .i_din(i_din), .i_din_kyz(i_din_kyz),
        .i_din_inv(i_din_inv), .i_db_ms(i_db_ms), .o_din_state(o_din_state),
        .o_din_event(o_din_event), .i_relay_mode(i_relay_mode),
        .i_relay_inv(i_relay_inv), .i_retain(i_retain),
        .i_saved_state(i_saved_state), .i_pulse_ms(i_pulse_ms),
        .i_src_sel(i_src_sel), .i_weight(i_weight),
        .i_sp_operate(i_sp_operate), .i_sp_release(i_sp_release),
        .i_cmd_valid(i_cmd_valid), .i_cmd_on(i_cmd_on),
        .i_energy_pulse(i_energy_pulse), .o_relay_coil(o_relay_coil),
        .o_relay_state(o_relay_state), .o_relay_busy(o_relay_busy));

    task automatic wrap_up;
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic do_reset;
        i_rst = 1'b1;
        cyc(8);
        i_rst = 1'b0;
        cyc(3);
    endtask

    task automatic cmd(input logic on);
        i_cmd_valid = 1'b1;
        i_cmd_on    = on;
        cyc(1);
        i_cmd_valid = 1'b0;
        cyc(4);
    endtask

    task automatic wait_idle;
        int k;
        for (k = 0; k < 3000 && o_relay_busy !== 1'b0; k++) cyc(1);
        if (k == 3000)
        begin
            `CHK("busy", 1'b0, o_relay_busy)
            wrap_up();
        end
    endtask

    task automatic t_restore;
        i_relay_mode  = `MPR_MODE_LATCHED;
        i_retain      = 1'b1;
        i_saved_state = 1'b1;
        i_relay_inv   = 1'b1;
        do_reset();
        `CHK("restored", 1'b1, o_relay_state)
        `CHK("coil", 1'b0, o_relay_coil)
        i_retain = 1'b0;
        do_reset();
        `CHK("restored", 1'b0, o_relay_state)
        `CHK("coil", 1'b1, o_relay_coil)
        i_relay_inv = 1'b0;
    endtask

    task automatic t_latched;
        i_sp_operate = 1'b1;
        cyc(3);
        i_sp_operate = 1'b0;
        cyc(4);
        `CHK("latched", 1'b1, o_relay_state)
        i_sp_release = 1'b1;
        cyc(1);
        i_sp_release = 1'b0;
        cyc(4);
        `CHK("released", 1'b0, o_relay_state)
        cmd(1'b1);
        `CHK("remote on", 1'b1, o_relay_state)
        cmd(1'b0);
        `CHK("remote off", 1'b0, o_relay_state)
        // With the enable low a command must leave the relay untouched
        i_ce = 1'b0;
        cmd(1'b1);
        `CHK("frozen", 1'b0, o_relay_state)
        i_ce = 1'b1;
    endtask

    task automatic t_unlatched;
        i_relay_mode = `MPR_MODE_UNLATCHED;
        i_sp_operate = 1'b1;
        cyc(4);
        `CHK("coil on", 1'b1, o_relay_coil)
        i_sp_operate = 1'b0;
        cyc(4);
        `CHK("coil off", 1'b0, o_relay_coil)
    endtask

    // Every mode/polarity pair on input 0; input 1 relies on the shared time
    task automatic t_inputs;
        for (int m = 0; m < 4; m++)
        begin
            i_din_kyz[0] = m[1];
            i_din_inv[0] = m[0];
            ev0 = 0;
            lvl = 2'h3;
            cyc(12);
            lvl = 2'h0;
            cyc(40);
            `CHK("glitch", 0, ev0)
            chat[0] = 1'b1;
            cyc(6);
            chat[0] = 1'b0;
            lvl = 2'h3;
            cyc(40);
            `CHK("state", 2'h3, o_din_state)
            lvl = 2'h0;
            cyc(40);
            `CHK("events", m[1] ? 2 : 1, ev0)
        end
    endtask

    task automatic t_pulse;
        i_relay_mode = `MPR_MODE_PULSE;
        i_src_sel    = 3'h1;
        rises = 0;
        for (int k = 1; k < 7; k++)
        begin
            i_energy_pulse = (k < 3) ? 7'h02 : 7'h01;
            cyc(1);
        end
        i_energy_pulse = 7'h00;
        cyc(300);
        wait_idle();
        `CHK("pulses", 2, rises)
        i_relay_mode = `MPR_MODE_UNLATCHED;
        i_energy_pulse = 7'h01;
        cyc(2);
        i_energy_pulse = 7'h00;
        cyc(10);
        `CHK("no link", 2, rises)
    endtask

    task automatic t_kyz;
        i_relay_mode = `MPR_MODE_KYZ;
        i_src_sel    = 3'h0;
        cyc(2);
        cmd(1'b0);
        `CHK("toggle", 1'b1, o_relay_state)
        `CHK("busy", 1'b1, o_relay_busy)
        wait_idle();
        cmd(1'b0);
        `CHK("toggle", 1'b0, o_relay_state)
        wait_idle();
        i_sp_operate = 1'b1;
        cyc(5);
        `CHK("toggle", 1'b1, o_relay_state)
    endtask

    initial
    begin
        do_reset();
        t_restore();
        t_latched();
        t_unlatched();
        t_inputs();
        t_pulse();
        t_kyz();
        wrap_up();
    end
endmodule // tb_top
